// ===== src/adcc_map.svh
// Register map, field positions and timing counts of the converter control block
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFS_MAIN    8'h00
`define ADCC_OFS_PINCFG  8'h04
`define ADCC_OFS_TIMING  8'h08
`define ADCC_OFS_RES_HI  8'h0c
`define ADCC_OFS_RES_LO  8'h10
`define ADCC_OFS_STATUS  8'h14
`define ADCC_OFS_MASK    8'h18
`define ADCC_MAIN_CAL    7
`define ADCC_MAIN_CHS_HI 5
`define ADCC_MAIN_CHS_LO 2
`define ADCC_MAIN_GO     1
`define ADCC_MAIN_ON     0
`define ADCC_MAIN_WMASK  8'hbf
`define ADCC_PIN_WMASK   8'h3f
`define ADCC_TFC_WMASK   8'hbf
`define ADCC_TFC_RJUST   7
`define ADCC_RESET_BYTE  8'h00
`define ADCC_ALL_ANALOG  12'hfff
`define ADCC_PCFG_BASE   4'h3
`define ADCC_CONV_TADS   5'h0b
`define ADCC_ACQ_0       5'h00
`define ADCC_ACQ_1       5'h02
`define ADCC_ACQ_2       5'h04
`define ADCC_ACQ_3       5'h06
`define ADCC_ACQ_4       5'h08
`define ADCC_ACQ_5       5'h0c
`define ADCC_ACQ_6       5'h10
`define ADCC_ACQ_7       5'h14
`define ADCC_DIV_0       7'h02
`define ADCC_DIV_1       7'h08
`define ADCC_DIV_2       7'h20
`define ADCC_DIV_4       7'h04
`define ADCC_DIV_5       7'h10
`define ADCC_DIV_6       7'h40
`endif

// ===== src/adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_ACQ  = 2'b01,
        ADCC_CONV = 2'b11
    } adcc_state_e;
endpackage : adcc_pkg

// ===== src/adcc_top.sv
// Converter control block: APB registers, acquisition and conversion sequencer
// Behaviour
// RL1: Twelve analog inputs, numbered zero to eleven, selectable for conversion.
// RL2: Each conversion yields a 10-bit unsigned result readable by software.
// RL3: Result high, result low and three control registers are offered.
// RL4: Main control bit 7 requests calibration on the next conversion.
// RL5: Main control bits 5..2 pick the channel; codes 11xx unused.
// RL6: Main control bit 1 reads one while converting, zero when idle.
// RL7: Main control bit 0 switches the converter module on or off.
// RL8: Main bit 6 and pin config bits 7..6 always read zero.
// RL9: Pin config bit 5 picks negative reference: external input 2 or ground.
// RL10: Pin config bit 4 picks positive reference: external input 3 or supply.
// RL11: Port code up to 0011 all analog; code k makes 11 down to 15-k digital.
// RL12: Implemented control bits are read/write and reset to zero.
// RL13: Pin config decides analog or digital use of each converter pin.
// RL14: Third control register holds clock source, acquisition time, justification.
// RL15: On completion load result, clear go bit, set the done flag.
// RL16: Go with zero acquisition converts at once, else samples first.
// RL17: A conversion lasts eleven conversion bit periods after sampling.
// RL18: Reset turns converter off, aborts conversion, keeps result registers.
// RL19: Writes to unimplemented control bits are ignored.
`include "adcc_map.svh"
module adcc_top #(
    parameter int FRC_DIV = 4
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  core_result,
    output logic             converter_on,
    output logic             core_sample,
    output logic             core_convert,
    output logic             core_bit_tick,
    output logic             calibrate_next,
    output logic      [3:0]  channel_select,
    output logic             neg_ref_select,
    output logic             pos_ref_select,
    output logic      [11:0] pin_analog_config,
    output logic             conversion_done_irq
);
    localparam logic [6:0] FRC_D = 7'(FRC_DIV);

    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        logic [4:0] r;
        r = `ADCC_ACQ_0;
        unique case (code)
            3'h0: r = `ADCC_ACQ_0;
            3'h1: r = `ADCC_ACQ_1;
            3'h2: r = `ADCC_ACQ_2;
            3'h3: r = `ADCC_ACQ_3;
            3'h4: r = `ADCC_ACQ_4;
            3'h5: r = `ADCC_ACQ_5;
            3'h6: r = `ADCC_ACQ_6;
            3'h7: r = `ADCC_ACQ_7;
        endcase
        return r;
    endfunction : acq_tads

    function automatic logic [6:0] tad_div(input logic [2:0] code);
        logic [6:0] r;
        r = FRC_D;
        unique case (code)
            3'h0: r = `ADCC_DIV_0;
            3'h1: r = `ADCC_DIV_1;
            3'h2: r = `ADCC_DIV_2;
            3'h4: r = `ADCC_DIV_4;
            3'h5: r = `ADCC_DIV_5;
            3'h6: r = `ADCC_DIV_6;
            3'h3, 3'h7: r = FRC_D;
        endcase
        return r;
    endfunction : tad_div

    // Analog mask, one per input
    function automatic logic [11:0] pin_mask(input logic [3:0] code);
        logic [3:0] sh;
        sh = code - `ADCC_PCFG_BASE;
        if (code <= `ADCC_PCFG_BASE) begin
            return `ADCC_ALL_ANALOG;
        end
        return `ADCC_ALL_ANALOG >> sh;
    endfunction : pin_mask

    adcc_pkg::adcc_state_e st_q, st_d;
    logic [7:0]  main_q, main_d;
    logic [7:0]  pin_q, pin_d;
    logic [7:0]  tfc_q, tfc_d;
    logic [7:0]  rhi_q, rhi_d;
    logic [7:0]  rlo_q, rlo_d;
    logic        sts_q, sts_d;
    logic        msk_q, msk_d;
    logic [6:0]  div_q, div_d;
    logic [4:0]  tad_q, tad_d;
    logic [31:0] prd_q, prd_d;
    logic        rdy_q, rdy_d;
    logic        err_q, err_d;
    logic        smp_q, smp_d;
    logic        cnv_q, cnv_d;
    logic        btk_q, btk_d;
    logic [11:0] pam_q, pam_d;
    logic        irq_q, irq_d;
    logic        acc;
    logic        wr;
    logic        mapped;
    logic        tick;
    logic        start;
    logic        done_evt;
    logic [7:0]  wmain;

    assign acc = psel & penable & rdy_q;
    assign wr  = acc & pwrite;
    assign mapped = (paddr == `ADCC_OFS_MAIN) | (paddr == `ADCC_OFS_PINCFG)
                  | (paddr == `ADCC_OFS_TIMING) | (paddr == `ADCC_OFS_RES_HI)
                  | (paddr == `ADCC_OFS_RES_LO) | (paddr == `ADCC_OFS_STATUS)
                  | (paddr == `ADCC_OFS_MASK);
    assign wmain = pwdata[7:0] & `ADCC_MAIN_WMASK; // see RL19
    assign tick = (st_q != adcc_pkg::ADCC_IDLE) && (div_q == tad_div(tfc_q[2:0]) - 7'h01);
    assign start = wr && (paddr == `ADCC_OFS_MAIN) && wmain[`ADCC_MAIN_GO]
                 && wmain[`ADCC_MAIN_ON] && (st_q == adcc_pkg::ADCC_IDLE);
    assign done_evt = (st_q == adcc_pkg::ADCC_CONV) && tick && (tad_q == 5'h01);

    // Bus slave and registers
    always_comb begin
        main_d = main_q;
        pin_d  = pin_q;
        tfc_d  = tfc_q;
        sts_d  = sts_q | done_evt; // see RL15
        msk_d  = msk_q;
        rdy_d  = psel & penable & ~rdy_q;
        prd_d  = prd_q;
        err_d  = 1'b0;
        if (psel & penable & ~rdy_q) begin
            err_d = ~mapped;
            prd_d = 32'h0;
            unique case (paddr)
                `ADCC_OFS_MAIN:   prd_d[7:0] = {main_q[7:2], st_q != adcc_pkg::ADCC_IDLE, main_q[0]}; // see RL6
                `ADCC_OFS_PINCFG: prd_d[7:0] = pin_q;  // see RL8
                `ADCC_OFS_TIMING: prd_d[7:0] = tfc_q;  // see RL14
                `ADCC_OFS_RES_HI: prd_d[7:0] = rhi_q;  // see RL3
                `ADCC_OFS_RES_LO: prd_d[7:0] = rlo_q;
                `ADCC_OFS_STATUS: prd_d[0]   = sts_q;
                `ADCC_OFS_MASK:   prd_d[0]   = msk_q;
                default:          prd_d      = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                `ADCC_OFS_MAIN:   main_d = {wmain[7:2], 1'b0, wmain[0]}; // see RL7
                `ADCC_OFS_PINCFG: pin_d  = pwdata[7:0] & `ADCC_PIN_WMASK; // see RL12
                `ADCC_OFS_TIMING: tfc_d  = pwdata[7:0] & `ADCC_TFC_WMASK;
                `ADCC_OFS_STATUS: sts_d  = (sts_q & ~pwdata[0]) | done_evt;
                `ADCC_OFS_MASK:   msk_d  = pwdata[0];
                default: begin
                end
            endcase
        end
        irq_d = sts_d & msk_d;
    end

    // Acquisition and conversion sequencer
    always_comb begin
        st_d  = st_q;
        div_d = tick ? 7'h00 : div_q + 7'h01;
        tad_d = tad_q;
        rhi_d = rhi_q;
        rlo_d = rlo_q;
        unique case (st_q)
            adcc_pkg::ADCC_IDLE: begin
                div_d = 7'h00;
                if (start) begin
                    if (acq_tads(tfc_q[5:3]) == `ADCC_ACQ_0) begin
                        st_d  = adcc_pkg::ADCC_CONV; // see RL16
                        tad_d = `ADCC_CONV_TADS;
                    end else begin
                        st_d  = adcc_pkg::ADCC_ACQ;
                        tad_d = acq_tads(tfc_q[5:3]);
                    end
                end
            end
            adcc_pkg::ADCC_ACQ: begin
                if (tick) begin
                    tad_d = tad_q - 5'h01;
                    if (tad_q == 5'h01) begin
                        st_d  = adcc_pkg::ADCC_CONV;
                        tad_d = `ADCC_CONV_TADS; // see RL17
                    end
                end
            end
            adcc_pkg::ADCC_CONV: begin
                if (tick) begin
                    tad_d = tad_q - 5'h01;
                end
                if (done_evt) begin
                    st_d = adcc_pkg::ADCC_IDLE; // see RL15
                    if (tfc_q[`ADCC_TFC_RJUST]) begin
                        rhi_d = {6'h00, core_result[9:8]}; // see RL2
                        rlo_d = core_result[7:0];
                    end else begin
                        rhi_d = core_result[9:2];
                        rlo_d = {core_result[1:0], 6'h00};
                    end
                end
            end
            default: st_d = adcc_pkg::ADCC_IDLE;
        endcase
        // Module off or go cleared aborts
        if (!main_d[`ADCC_MAIN_ON]) begin
            st_d = adcc_pkg::ADCC_IDLE; // see RL7
        end else if (wr && (paddr == `ADCC_OFS_MAIN) && !wmain[`ADCC_MAIN_GO]) begin
            st_d = adcc_pkg::ADCC_IDLE;
        end
        smp_d = main_d[`ADCC_MAIN_ON] && (st_d != adcc_pkg::ADCC_CONV);
        cnv_d = (st_d == adcc_pkg::ADCC_CONV);
        btk_d = tick && (st_q == adcc_pkg::ADCC_CONV);
        pam_d = pin_mask(pin_d[3:0]); // see RL11, RL13
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q  <= adcc_pkg::ADCC_IDLE; // see RL18
            main_q <= `ADCC_RESET_BYTE;
            pin_q <= `ADCC_RESET_BYTE;
            tfc_q <= `ADCC_RESET_BYTE;
            sts_q <= 1'b0;
            msk_q <= 1'b0;
            div_q <= 7'h00;
            tad_q <= 5'h00;
            prd_q <= 32'h0;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            smp_q <= 1'b0;
            cnv_q <= 1'b0;
            btk_q <= 1'b0;
            pam_q <= `ADCC_ALL_ANALOG;
            irq_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            main_q <= main_d;
            pin_q <= pin_d;
            tfc_q <= tfc_d;
            sts_q <= sts_d;
            msk_q <= msk_d;
            div_q <= div_d;
            tad_q <= tad_d;
            prd_q <= prd_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            smp_q <= smp_d;
            cnv_q <= cnv_d;
            btk_q <= btk_d;
            pam_q <= pam_d;
            irq_q <= irq_d;
        end
    end

    // Result registers survive reset
    always_ff @(posedge mclk) begin
        rhi_q <= rhi_d; // see RL18
        rlo_q <= rlo_d;
    end

    assign prdata = prd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign converter_on = main_q[`ADCC_MAIN_ON];
    assign core_sample = smp_q;
    assign core_convert = cnv_q;
    assign core_bit_tick = btk_q;
    assign calibrate_next = main_q[`ADCC_MAIN_CAL]; // see RL4
    assign channel_select = main_q[`ADCC_MAIN_CHS_HI:`ADCC_MAIN_CHS_LO]; // see RL1, RL5
    assign neg_ref_select = pin_q[5]; // see RL9
    assign pos_ref_select = pin_q[4]; // see RL10
    assign pin_analog_config = pam_q;
    assign conversion_done_irq = irq_q;

    // Checks
    logic [4:0] chk_ticks_q;
    always_ff @(posedge mclk) begin
        if (!rst_n || !cnv_q) begin
            chk_ticks_q <= 5'h00;
        end else if (btk_q) begin
            chk_ticks_q <= chk_ticks_q + 5'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_main_unused;
        acc && !pwrite && (paddr == `ADCC_OFS_MAIN) |-> (prdata[6] == 1'b0) && (prdata[31:8] == 24'h0);
    endproperty
    a_main_unused: assert property (p_main_unused) else $error("main control reserved bits not zero"); // see RL8
    property p_busy_on;
        (st_q != adcc_pkg::ADCC_IDLE) |-> converter_on;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy while converter off"); // see RL6
    property p_off_idle;
        wr && (paddr == `ADCC_OFS_MAIN) && !pwdata[0] |=> (st_q == adcc_pkg::ADCC_IDLE) && !core_convert;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("converter not stopped when off"); // see RL7
    property p_eleven;
        $fell(core_convert) && $past(done_evt) |-> core_bit_tick && (chk_ticks_q == 5'h0a);
    endproperty
    a_eleven: assert property (p_eleven) else $error("conversion not eleven bit periods"); // see RL17
    property p_done;
        done_evt |=> sts_q && (st_q == adcc_pkg::ADCC_IDLE);
    endproperty
    a_done: assert property (p_done) else $error("done flag or go bit wrong"); // see RL15
    property p_acq_zero;
        start && (tfc_q[5:3] == 3'h0) |=> core_convert;
    endproperty
    a_acq_zero: assert property (p_acq_zero) else $error("zero acquisition did not convert"); // see RL16
    property p_acq_long;
        start && (tfc_q[5:3] != 3'h0) |=> !core_convert [*2];
    endproperty
    a_acq_long: assert property (p_acq_long) else $error("acquisition skipped"); // see RL16
    property p_reset;
        disable iff (1'b0) !rst_n |=> (main_q == 8'h00) && (pin_q == 8'h00) && (st_q == adcc_pkg::ADCC_IDLE);
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong"); // see RL12
    property p_pins_dig;
        (pin_q[3:0] == 4'hf) |-> (pin_analog_config == 12'h000);
    endproperty
    a_pins_dig: assert property (p_pins_dig) else $error("code 1111 not all digital"); // see RL11
    property p_wmask;
        wr && (paddr == `ADCC_OFS_PINCFG) |=> (pin_q[7:6] == 2'b00);
    endproperty
    a_wmask: assert property (p_wmask) else $error("reserved pin config bits written"); // see RL19
    property p_irq;
        sts_q && msk_q |-> conversion_done_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    c_conv: cover property (done_evt);
    c_acq: cover property (st_q == adcc_pkg::ADCC_ACQ ##1 st_q == adcc_pkg::ADCC_CONV);
    c_irq: cover property ($rose(conversion_done_irq));
    c_err: cover property (pslverr);
endmodule : adcc_top

// ===== tb/adcc_core_model.sv
// Behavioural converter core answering with a channel-coded result
module adcc_core_model (
    input  wire logic       core_convert,
    input  wire logic [3:0] channel_select,
    output logic      [9:0] core_result
);
    timeunit 1ns;
    timeprecision 1ns;
    // Inverted outside conversion so a stale sample shows
    assign core_result = core_convert ? {channel_select, 6'h15} : ~{channel_select, 6'h15};
endmodule : adcc_core_model

// ===== tb/test_adcc_top.sv
// Self-checking bench for the converter control block
`include "adcc_map.svh"
module test_adcc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, converter_on, core_sample, core_convert, core_bit_tick;
    logic        calibrate_next, neg_ref_select, pos_ref_select, conversion_done_irq, last_err;
    logic [3:0]  channel_select;
    logic [9:0]  core_result, res;
    logic [11:0] pin_analog_config;
    int          mismatches = 0, compares = 0, cyc = 0, conv_cyc = 0, ticks = 0, rise_at = 0, start_at = 0;

    adcc_top #(.FRC_DIV(2)) u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .core_result, .converter_on, .core_sample, .core_convert, .core_bit_tick,
        .calibrate_next, .channel_select, .neg_ref_select, .pos_ref_select, .pin_analog_config,
        .conversion_done_irq);
    adcc_core_model u_core (.core_convert, .channel_select, .core_result);

    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (core_convert === 1'b1 && conv_cyc == 0) rise_at = cyc;
        if (core_convert === 1'b1) conv_cyc++;
        if (core_bit_tick === 1'b1) ticks++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
        chk("pready", pready, 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(what, r, {24'h0, exp});
    endtask : rd

    task automatic run_conv(input logic [7:0] tfc, input logic [3:0] ch);
        logic [31:0] r;
        int n;
        wr(`ADCC_OFS_TIMING, tfc);
        wr(`ADCC_OFS_MAIN, {2'b00, ch, 2'b01});
        conv_cyc = 0; ticks = 0; rise_at = 0;
        wr(`ADCC_OFS_MAIN, {2'b00, ch, 2'b11});
        start_at = cyc;
        apb(1'b0, `ADCC_OFS_MAIN, 32'h0, r);
        chk("go busy", r[1], 1'b1);
        n = 0;
        do begin apb(1'b0, `ADCC_OFS_MAIN, 32'h0, r); n++; end while (r[1] !== 1'b0 && n < 200);
        chk("go done", r[1], 1'b0);
        res = {ch, 6'h15};
    endtask : run_conv

    task automatic t_reset();
        rd(`ADCC_OFS_MAIN, 8'h00, "main");
        rd(`ADCC_OFS_PINCFG, 8'h00, "pincfg");
        rd(`ADCC_OFS_TIMING, 8'h00, "timing");
        chk("analog map", pin_analog_config, 12'hfff);
        chk("on", converter_on, 1'b0);
        chk("sample", core_sample, 1'b0);
    endtask : t_reset

    task automatic t_fields();
        wr(`ADCC_OFS_MAIN, 8'hfc);
        rd(`ADCC_OFS_MAIN, 8'hbc, "main");
        chk("cal", calibrate_next, 1'b1);
        chk("chan", channel_select, 4'hf);
        wr(`ADCC_OFS_PINCFG, 8'hff);
        rd(`ADCC_OFS_PINCFG, 8'h3f, "pincfg");
        chk("negref", neg_ref_select, 1'b1);
        chk("posref", pos_ref_select, 1'b1);
        wr(`ADCC_OFS_TIMING, 8'hff);
        rd(`ADCC_OFS_TIMING, 8'hbf, "timing");
        wr(`ADCC_OFS_MAIN, 8'h00);
        rd(`ADCC_OFS_MAIN, 8'h00, "main");
    endtask : t_fields

    task automatic t_pins();
        for (int k = 0; k < 16; k++) begin
            wr(`ADCC_OFS_PINCFG, k[7:0]);
            @(negedge mclk);
            chk("analog map", pin_analog_config, (k <= 3) ? 12'hfff : 12'hfff >> (k - 3));
        end
    endtask : t_pins

    task automatic t_unmapped();
        rd(8'h1c, 8'h00, "unmapped");
        chk("slverr", last_err, 1'b1);
        wr(8'h1c, 8'hff);
        rd(`ADCC_OFS_MAIN, 8'h00, "main");
    endtask : t_unmapped

    task automatic t_conv_right();
        wr(`ADCC_OFS_MASK, 8'h01);
        run_conv(8'h80, 4'h5);
        chk("conv cycles", conv_cyc, 32'd22);
        chk("bit ticks", ticks, 32'd11);
        chk("no acq", (rise_at - start_at) <= 2, 1'b1);
        rd(`ADCC_OFS_RES_HI, {6'h00, res[9:8]}, "res hi");
        rd(`ADCC_OFS_RES_LO, res[7:0], "res lo");
        rd(`ADCC_OFS_MAIN, 8'h15, "main done");
        rd(`ADCC_OFS_STATUS, 8'h01, "status");
        chk("irq", conversion_done_irq, 1'b1);
        chk("sample", core_sample, 1'b1);
        wr(`ADCC_OFS_STATUS, 8'h01);
        rd(`ADCC_OFS_STATUS, 8'h00, "status");
        chk("irq", conversion_done_irq, 1'b0);
    endtask : t_conv_right

    task automatic t_conv_left();
        wr(`ADCC_OFS_MASK, 8'h00);
        run_conv(8'h0c, 4'hb);
        chk("conv cycles", conv_cyc, 32'd44);
        chk("acq wait", (rise_at - start_at) >= 8, 1'b1);
        chk("irq masked", conversion_done_irq, 1'b0);
        rd(`ADCC_OFS_STATUS, 8'h01, "status");
        rd(`ADCC_OFS_RES_HI, res[9:2], "res hi");
        rd(`ADCC_OFS_RES_LO, {res[1:0], 6'h00}, "res lo");
        wr(`ADCC_OFS_STATUS, 8'h01);
    endtask : t_conv_left

    task automatic t_reset_abort();
        wr(`ADCC_OFS_TIMING, 8'h02);
        wr(`ADCC_OFS_MAIN, 8'h0f);
        repeat (20) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("on", converter_on, 1'b0);
        chk("convert", core_convert, 1'b0);
        chk("sample", core_sample, 1'b0);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd(`ADCC_OFS_RES_HI, res[9:2], "res hi");
        rd(`ADCC_OFS_RES_LO, {res[1:0], 6'h00}, "res lo");
        rd(`ADCC_OFS_MAIN, 8'h00, "main");
    endtask : t_reset_abort

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_pins();
        t_unmapped();
        t_conv_right();
        t_conv_left();
        t_reset_abort();
        tally_and_finish();
    end

    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
endmodule : test_adcc_top
